// file: hw/pmtel_top.sv
// Purpose: converter control, rail telemetry, die temperature, address ID
// Assumes: converter and pin sensors are digitised outside this block
// Notes: register port is the management bus engine's internal side
//
// Overview of operation
// RQ1: Bits 7 to 3 of 0x30 enable the converter and pick its voltage input.
// RQ2: The selected channel's converted voltage lands in the byte at 0x31.
// RQ3: Bits 6 to 3 pick buck rail A, B, C, bulk input, high LDO or low LDO.
// RQ4: Rail readings update continuously in 0x0C[7:0], 0x0E[5:0], 0x0F[5:0].
// RQ5: Bit 6 of 0x1B selects current when clear and power when set.
// RQ6: Bits 1 to 0 of 0x30 set the averaging window and the refresh rate.
// RQ7: In power mode bit 1 of 0x1A puts the sum of all three rails into 0x0C.
// RQ8: Die temperature is reported as a three-bit code in 0x33[7:5].
// RQ9: Temperature conversion runs on its own while the die is above 85 C.
// RQ10: The ID pin is sampled once, when the bulk supply first comes up.
// RQ11: Ground gives ID 1001, floating gives 1000, high LDO rail gives 1100.
// RQ12: Measurement results cannot be altered by host writes.
`default_nettype none
module pmtel_top
  import pmtel_pkg::*;
(
  input wire logic CLOCK, // 25 MHz core clock
  input wire logic RESETN, // async reset, active low
  input wire logic [7:0] REG_ADDR, // register offset
  input wire logic REG_WR, // write strobe
  input wire logic [7:0] REG_WDATA, // write data
  input wire logic REG_RD, // read strobe
  output logic [7:0] REG_RDATA, // read data, valid cycle after REG_RD
  output logic CONV_EN, // converter enable
  output logic [3:0] CONV_CH, // voltage mux select
  input wire logic VOLT_VALID, // voltage sample strobe
  input wire logic [7:0] VOLT_CODE, // voltage sample
  input wire logic RAIL_VALID, // rail sample strobe
  input wire logic [7:0] RAIL_A_CUR, // rail A current sample
  input wire logic [7:0] RAIL_B_CUR, // rail B current sample
  input wire logic [7:0] RAIL_C_CUR, // rail C current sample
  input wire logic [7:0] RAIL_A_PWR, // rail A power sample
  input wire logic [7:0] RAIL_B_PWR, // rail B power sample
  input wire logic [7:0] RAIL_C_PWR, // rail C power sample
  input wire logic DIE_HOT, // async, die above 85 C
  input wire logic TEMP_VALID, // temperature sample strobe
  input wire logic [2:0] TEMP_CODE, // temperature sample
  output logic TEMP_CONV_EN, // temperature converter run
  input wire logic BULK_GOOD, // async, bulk supply present
  input wire logic ADDR_ID_LOW, // async, address_id_pin at ground
  input wire logic ADDR_ID_HIGH, // async, address_id_pin at high_ldo_rail
  output logic [3:0] MGMT_ID, // latched bus identity
  output logic MGMT_ID_VALID // identity has been latched
);
  typedef enum logic {PMTEL_WAIT_BULK, PMTEL_LATCHED} pmtel_id_type;

  function automatic logic [7:0] sat8(input logic [9:0] v,
    input logic [7:0] m);
    // clamp to the width of the register field
    sat8 = (v > {2'h0, m}) ? m : v[7:0];
  endfunction

  // ************************************************************
  // synchronisers
  // ************************************************************
  // pins and the hot flag arrive asynchronously; only sync_r feeds logic
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
    end else begin
      meta_r <= {DIE_HOT, BULK_GOOD, ADDR_ID_LOW, ADDR_ID_HIGH};
      sync_r <= meta_r;
    end
  end
  wire hot_s = sync_r[3];
  wire bulk_s = sync_r[2];
  // id pins share the bulk flag's latency, so the code is settled
  wire id_gnd_s = sync_r[1];
  wire id_ldo_s = sync_r[0];

  // ************************************************************
  // register decode
  // ************************************************************
  logic [7:0] ctrl_r, psum_cfg_r, cpsel_cfg_r;
  logic [7:0] volt_r, temp_r, rdata_r;
  logic [7:0] rail_r [3];
  wire wr_ctrl = REG_WR && REG_ADDR == PMTEL_OFS_CONV_CTRL;
  wire wr_psum = REG_WR && REG_ADDR == PMTEL_OFS_PSUM_CFG;
  wire wr_cpsel = REG_WR && REG_ADDR == PMTEL_OFS_CPSEL_CFG;
  wire pwr_mode = cpsel_cfg_r[PMTEL_PWR_SEL_BIT]; // RQ5
  wire sum_mode = pwr_mode && psum_cfg_r[PMTEL_PSUM_BIT]; // RQ7
  wire [3:0] ch_sel = ctrl_r[6:PMTEL_CTRL_CH_LSB]; // RQ3
  wire ch_ok = ch_sel <= PMTEL_CH_LOW_LDO; // RQ3
  // unmapped offsets read as zero and drop writes
  wire [7:0] rd_mux =
    (REG_ADDR == PMTEL_OFS_RAIL_A) ? rail_r[0] :
    (REG_ADDR == PMTEL_OFS_RAIL_B) ? rail_r[1] :
    (REG_ADDR == PMTEL_OFS_RAIL_C) ? rail_r[2] :
    (REG_ADDR == PMTEL_OFS_PSUM_CFG) ? psum_cfg_r :
    (REG_ADDR == PMTEL_OFS_CPSEL_CFG) ? cpsel_cfg_r :
    (REG_ADDR == PMTEL_OFS_CONV_CTRL) ? ctrl_r :
    (REG_ADDR == PMTEL_OFS_VOLT_RES) ? volt_r :
    (REG_ADDR == PMTEL_OFS_TEMP) ? temp_r : PMTEL_RDATA_UNMAPPED;

  // result registers take no write path at all
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_r <= PMTEL_CTRL_RST;
      psum_cfg_r <= PMTEL_CFG_RST;
      cpsel_cfg_r <= PMTEL_CFG_RST;
      rdata_r <= PMTEL_RDATA_UNMAPPED;
    end else begin
      if (wr_ctrl) ctrl_r <= REG_WDATA; // RQ1 RQ6 RQ12
      if (wr_psum) psum_cfg_r <= REG_WDATA;
      if (wr_cpsel) cpsel_cfg_r <= REG_WDATA;
      if (REG_RD) rdata_r <= rd_mux;
    end
  end
  // read data holds until the next read strobe
  assign REG_RDATA = rdata_r;

  // ************************************************************
  // selected voltage
  // ************************************************************
  // codes above the low LDO leave the converter off
  assign CONV_EN = ctrl_r[PMTEL_CTRL_EN_BIT] && ch_ok; // RQ1
  assign CONV_CH = ch_sel; // RQ1
  // result byte keeps its last value while disabled
  wire volt_take = CONV_EN && VOLT_VALID; // RQ2
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) volt_r <= 8'h00;
    else if (volt_take) volt_r <= VOLT_CODE; // RQ2
  end

  // ************************************************************
  // rail averaging
  // ************************************************************
  // window length follows ctrl[1:0]; a change applies from the next sample, even mid-window
  wire [1:0] win_sel = ctrl_r[1:0]; // RQ6
  wire [2:0] win_log2 =
    (win_sel == 2'h0) ? PMTEL_WIN_LOG2_0 :
    (win_sel == 2'h1) ? PMTEL_WIN_LOG2_1 :
    (win_sel == 2'h2) ? PMTEL_WIN_LOG2_2 : PMTEL_WIN_LOG2_3; // RQ6
  logic [5:0] cnt_r;
  wire [5:0] cnt_last = 6'((7'h01 << win_log2) - 7'h01);
  wire win_end = RAIL_VALID && cnt_r >= cnt_last; // RQ6
  // sum saturates before averaging, so rail A never wraps
  wire [9:0] pwr_sum = {2'h0, RAIL_A_PWR} + {2'h0, RAIL_B_PWR}
    + {2'h0, RAIL_C_PWR};
  // mode is taken per sample; a switch mid-window mixes both kinds
  wire [7:0] samp [3];
  assign samp[0] = sum_mode ? sat8(pwr_sum, PMTEL_SAT8) :
    pwr_mode ? RAIL_A_PWR : RAIL_A_CUR; // RQ5 RQ7
  assign samp[1] = pwr_mode ? RAIL_B_PWR : RAIL_B_CUR; // RQ5
  assign samp[2] = pwr_mode ? RAIL_C_PWR : RAIL_C_CUR; // RQ5

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) cnt_r <= 6'h00;
    else if (win_end) cnt_r <= 6'h00;
    else if (RAIL_VALID) cnt_r <= cnt_r + 6'h01;
  end

  // 14-bit sums hold 64 full-scale samples without overflow
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_rail
      logic [13:0] acc_r;
      wire [13:0] acc_nxt = acc_r + {6'h00, samp[g]};
      wire [13:0] avg = acc_nxt >> win_log2;
      wire [7:0] lim = (g == 0) ? PMTEL_SAT8 : PMTEL_SAT6;
      always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
          acc_r <= 14'h0000;
          rail_r[g] <= 8'h00;
        end else if (win_end) begin
          acc_r <= 14'h0000;
          rail_r[g] <= sat8(avg[9:0], lim); // RQ4 RQ6
        end else if (RAIL_VALID) begin
          acc_r <= acc_nxt;
        end
      end
    end
  endgenerate

  // ************************************************************
  // die temperature
  // ************************************************************
  // conversion runs only while hot; no host request is needed
  assign TEMP_CONV_EN = hot_s; // RQ9
  // samples taken while the die is cool are dropped
  wire temp_take = hot_s && TEMP_VALID; // RQ9
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) temp_r <= 8'h00;
    else if (temp_take)
      temp_r <= {TEMP_CODE, 5'h00}; // RQ8
  end

  // ************************************************************
  // address ID capture
  // ************************************************************
  // one-shot: only a full reset re-arms the capture
  pmtel_id_type id_st_r, id_st_nxt;
  logic [3:0] id_r;
  // ground wins when both pin sensors fire
  wire [3:0] id_dec = id_gnd_s ? PMTEL_ID_GROUND :
    id_ldo_s ? PMTEL_ID_HIGH_LDO : PMTEL_ID_FLOAT; // RQ11
  wire id_take = id_st_r == PMTEL_WAIT_BULK && bulk_s; // RQ10
  always_comb begin
    case (id_st_r)
      PMTEL_WAIT_BULK: id_st_nxt = bulk_s ? PMTEL_LATCHED : PMTEL_WAIT_BULK;
      PMTEL_LATCHED: id_st_nxt = PMTEL_LATCHED;
      default: id_st_nxt = PMTEL_WAIT_BULK;
    endcase
  end
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      id_st_r <= PMTEL_WAIT_BULK;
      id_r <= PMTEL_ID_FLOAT;
    end else begin
      id_st_r <= id_st_nxt;
      if (id_take) id_r <= id_dec; // RQ10
    end
  end
  assign MGMT_ID = id_r;
  assign MGMT_ID_VALID = id_st_r == PMTEL_LATCHED;
endmodule
`default_nettype wire

// file: hw/pmtel_pkg.sv
// Purpose: constants shared by the telemetry and address-ID block
// Assumes: 8-bit register port driven by the management bus engine
// Notes: sample windows are counted in rail sample strobes
`default_nettype none
package pmtel_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] PMTEL_OFS_RAIL_A = 8'h0C;
  localparam logic [7:0] PMTEL_OFS_RAIL_B = 8'h0E;
  localparam logic [7:0] PMTEL_OFS_RAIL_C = 8'h0F;
  localparam logic [7:0] PMTEL_OFS_PSUM_CFG = 8'h1A;
  localparam logic [7:0] PMTEL_OFS_CPSEL_CFG = 8'h1B;
  localparam logic [7:0] PMTEL_OFS_CONV_CTRL = 8'h30;
  localparam logic [7:0] PMTEL_OFS_VOLT_RES = 8'h31;
  localparam logic [7:0] PMTEL_OFS_TEMP = 8'h33;
  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int PMTEL_CTRL_EN_BIT = 7;
  localparam int PMTEL_CTRL_CH_LSB = 3;
  localparam int PMTEL_PSUM_BIT = 1;
  localparam int PMTEL_PWR_SEL_BIT = 6;
  localparam int PMTEL_TEMP_LSB = 5;
  localparam logic [7:0] PMTEL_CTRL_RST = 8'h00;
  localparam logic [7:0] PMTEL_CFG_RST = 8'h00;
  localparam logic [7:0] PMTEL_RDATA_UNMAPPED = 8'h00;
  // ************************************************************
  // channel codes of the voltage mux
  // ************************************************************
  localparam logic [3:0] PMTEL_CH_BUCK_A = 4'h0;
  localparam logic [3:0] PMTEL_CH_BUCK_B = 4'h1;
  localparam logic [3:0] PMTEL_CH_BUCK_C = 4'h2;
  localparam logic [3:0] PMTEL_CH_BULK = 4'h3;
  localparam logic [3:0] PMTEL_CH_HIGH_LDO = 4'h4;
  localparam logic [3:0] PMTEL_CH_LOW_LDO = 4'h5;
  // ************************************************************
  // averaging windows, log2 of samples per window
  // ************************************************************
  localparam logic [2:0] PMTEL_WIN_LOG2_0 = 3'h3;
  localparam logic [2:0] PMTEL_WIN_LOG2_1 = 3'h4;
  localparam logic [2:0] PMTEL_WIN_LOG2_2 = 3'h5;
  localparam logic [2:0] PMTEL_WIN_LOG2_3 = 3'h6;
  // ************************************************************
  // address IDs and rail saturation limits
  // ************************************************************
  localparam logic [3:0] PMTEL_ID_GROUND = 4'h9;
  localparam logic [3:0] PMTEL_ID_FLOAT = 4'h8;
  localparam logic [3:0] PMTEL_ID_HIGH_LDO = 4'hC;
  localparam logic [7:0] PMTEL_SAT6 = 8'h3F;
  localparam logic [7:0] PMTEL_SAT8 = 8'hFF;
endpackage
`default_nettype wire

// file: test/pmtel_checker.sv
// Purpose: port properties of the telemetry block
// Assumes: register strobes are one-cycle pulses
// Notes: rail averaging values are judged by the bench
`default_nettype none
module pmtel_checker (
  input wire logic CLOCK, // clock
  input wire logic RESETN, // reset, active low
  input wire logic [7:0] REG_ADDR, // offset
  input wire logic REG_WR, // write
  input wire logic [7:0] REG_WDATA, // write data
  input wire logic REG_RD, // read
  input wire logic [7:0] REG_RDATA, // read data
  input wire logic CONV_EN, // converter on
  input wire logic [3:0] CONV_CH, // channel
  input wire logic VOLT_VALID, // sample strobe
  input wire logic [7:0] VOLT_CODE, // sample
  input wire logic DIE_HOT, // hot level
  input wire logic TEMP_CONV_EN, // temp run
  input wire logic [3:0] MGMT_ID, // identity
  input wire logic MGMT_ID_VALID // identity latched
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wd_r;
  logic [7:0] volt_r;
  always_ff @(posedge CLOCK) wd_r <= REG_WDATA;
  // shadow of the result byte; host writes never reach it
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN) volt_r <= 8'h00;
    else if (VOLT_VALID && CONV_EN) volt_r <= VOLT_CODE;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  chk_ctrl_chan: assert property (
    REG_WR && REG_ADDR == 8'h30 |=> CONV_CH == wd_r[6:3]) else $error("ch");
  chk_ctrl_enable: assert property (
    REG_WR && REG_ADDR == 8'h30 |=>
    CONV_EN == (wd_r[7] && wd_r[6:3] <= 4'h5)) else $error("enable");
  chk_volt_read: assert property (
    REG_RD && REG_ADDR == 8'h31 && !VOLT_VALID |=> REG_RDATA == volt_r)
    else $error("result byte");
  chk_read_hold: assert property (
    !REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  chk_rail_width: assert property (
    REG_RD && REG_ADDR inside {8'h0E, 8'h0F} |=> REG_RDATA[7:6] == 2'h0)
    else $error("rail width");
  chk_temp_follow: assert property (
    $changed(DIE_HOT) |-> ##2 TEMP_CONV_EN == $past(DIE_HOT, 2))
    else $error("temp run");
  chk_id_hold: assert property (
    MGMT_ID_VALID |=> MGMT_ID_VALID && $stable(MGMT_ID)) else $error("id");
  chk_id_code: assert property (
    MGMT_ID_VALID |-> MGMT_ID inside {4'h9, 4'h8, 4'hC}) else $error("code");
  cover property (VOLT_VALID && CONV_EN);
  cover property ($rose(TEMP_CONV_EN));
  cover property ($rose(MGMT_ID_VALID));
endmodule
bind pmtel_top pmtel_checker chk (.*);
`default_nettype wire

// file: test/pmtel_host.sv
// Purpose: host side of the register strobe port
// Assumes: one access at a time, launched on falling edges
// Notes: offset and data show junk between accesses
`default_nettype none
module pmtel_host (
  input wire logic CLOCK, // clock
  input wire logic [7:0] REG_RDATA, // read data
  output logic [7:0] REG_ADDR, // offset
  output logic REG_WR, // write
  output logic [7:0] REG_WDATA, // write data
  output logic REG_RD // read
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = 18'h00000;
  task automatic xfer(input logic w, input logic [7:0] a, d,
    output logic [7:0] q);
    @(negedge CLOCK);
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
    @(negedge CLOCK);
    // inverted leftovers so a stale offset never looks valid
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {2'h0, ~a, ~d};
    q = REG_RDATA;
  endtask
endmodule
`default_nettype wire

// file: test/pmtel_top_test.sv
// Purpose: register-level test of the telemetry block
// Assumes: sensor strobes and pins change on falling edges
// Notes: all four averaging windows are exercised
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end
module pmtel_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 1'b0;
  logic RESETN, VOLT_VALID, RAIL_VALID, TEMP_VALID, DIE_HOT, BULK_GOOD;
  logic ADDR_ID_LOW, ADDR_ID_HIGH;
  logic [2:0] TEMP_CODE;
  logic [7:0] VOLT_CODE, RAIL_A_CUR, RAIL_B_CUR, RAIL_C_CUR, q, e;
  logic [7:0] RAIL_A_PWR, RAIL_B_PWR, RAIL_C_PWR;
  logic [3:0] id_exp [3] = '{4'h9, 4'h8, 4'hC};
  logic [1:0] pin [3] = '{2'h1, 2'h0, 2'h2};
  wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  wire logic REG_WR, REG_RD, CONV_EN, TEMP_CONV_EN, MGMT_ID_VALID;
  wire logic [3:0] CONV_CH, MGMT_ID;
  int k, fail_count = 0, n_tests = 0, cyc = 0;
  pmtel_top dut (.*);
  pmtel_host host (.*);
  always #20 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic pulse(input int n, input logic [2:0] s);
    repeat (n) begin
      @(negedge CLOCK);
      {TEMP_VALID, RAIL_VALID, VOLT_VALID} = s;
      @(negedge CLOCK);
      {TEMP_VALID, RAIL_VALID, VOLT_VALID} = 3'h0;
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] r;
    host.xfer(1'b0, a, 8'h00, r);
    `CHK($sformatf("reg %h", a), x, r)
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    {RESETN, VOLT_VALID, RAIL_VALID, TEMP_VALID, DIE_HOT, BULK_GOOD} = 6'h00;
    {ADDR_ID_LOW, ADDR_ID_HIGH, TEMP_CODE, VOLT_CODE, e} = '0;
    {RAIL_A_CUR, RAIL_B_CUR, RAIL_C_CUR} = 24'h405010;
    {RAIL_A_PWR, RAIL_B_PWR, RAIL_C_PWR} = 24'hFFFFFF;
    for (k = 0; k < 3; k++) begin
      {ADDR_ID_HIGH, ADDR_ID_LOW} = pin[k];
      BULK_GOOD = 1'b0;
      RESETN = 1'b0;
      repeat (10) @(negedge CLOCK);
      RESETN = 1'b1;
      `CHK("id valid", 1'b0, MGMT_ID_VALID)
      BULK_GOOD = 1'b1;
      repeat (4) @(negedge CLOCK);
      {ADDR_ID_HIGH, ADDR_ID_LOW} = ~pin[k];
      repeat (4) @(negedge CLOCK);
      `CHK("id", id_exp[k], MGMT_ID)
      `CHK("id valid", 1'b1, MGMT_ID_VALID)
    end
    for (k = 0; k < 8; k++) begin
      host.xfer(1'b1, 8'h30, {1'b1, 4'(k), 3'h0}, q);
      `CHK("channel", 4'(k), CONV_CH)
      `CHK("enable", k < 6, CONV_EN)
      VOLT_CODE = 8'h10 + 8'(k);
      pulse(1, 3'h1);
      e = (k < 6) ? VOLT_CODE : e;
      host.xfer(1'b1, 8'h31, 8'hAA, q);
      rc(8'h31, e);
    end
    rc(8'h30, 8'hB8);
    TEMP_CODE = 3'h5;
    pulse(1, 3'h4);
    rc(8'h33, 8'h00);
    `CHK("temp idle", 1'b0, TEMP_CONV_EN)
    DIE_HOT = 1'b1;
    repeat (3) @(negedge CLOCK);
    `CHK("temp run", 1'b1, TEMP_CONV_EN)
    pulse(1, 3'h4);
    rc(8'h33, 8'hA0);
    pulse(8, 3'h2);
    rc(8'h0C, 8'h40);
    rc(8'h0E, 8'h3F);
    rc(8'h0F, 8'h10);
    host.xfer(1'b1, 8'h1B, 8'h40, q);
    {RAIL_A_CUR, RAIL_B_CUR, RAIL_C_CUR} = 24'hFFFFFF;
    {RAIL_A_PWR, RAIL_B_PWR, RAIL_C_PWR} = 24'h200804;
    pulse(8, 3'h2);
    rc(8'h0C, 8'h20);
    rc(8'h0E, 8'h08);
    rc(8'h0F, 8'h04);
    host.xfer(1'b1, 8'h1A, 8'h02, q);
    host.xfer(1'b1, 8'h30, 8'h01, q);
    pulse(8, 3'h2);
    rc(8'h0C, 8'h20);
    pulse(8, 3'h2);
    rc(8'h0C, 8'h2C);
    rc(8'h1A, 8'h02);
    rc(8'h1B, 8'h40);
    host.xfer(1'b1, 8'h0C, 8'h55, q);
    host.xfer(1'b1, 8'h33, 8'h55, q);
    rc(8'h0C, 8'h2C);
    rc(8'h33, 8'hA0);
    host.xfer(1'b1, 8'h1B, 8'h00, q);
    host.xfer(1'b1, 8'h30, 8'h02, q);
    {RAIL_A_CUR, RAIL_B_CUR, RAIL_C_CUR} = 24'h100802;
    pulse(16, 3'h2);
    {RAIL_A_CUR, RAIL_B_CUR, RAIL_C_CUR} = 24'h30283E;
    pulse(15, 3'h2);
    rc(8'h0C, 8'h2C);
    pulse(1, 3'h2);
    rc(8'h0C, 8'h20);
    rc(8'h0E, 8'h18);
    rc(8'h0F, 8'h20);
    host.xfer(1'b1, 8'h30, 8'h03, q);
    {RAIL_A_CUR, RAIL_B_CUR, RAIL_C_CUR} = 24'hF04001;
    pulse(63, 3'h2);
    rc(8'h0C, 8'h20);
    pulse(1, 3'h2);
    rc(8'h0C, 8'hF0);
    rc(8'h0E, 8'h3F);
    rc(8'h0F, 8'h01);
    host.xfer(1'b1, 8'h1B, 8'h40, q);
    host.xfer(1'b1, 8'h30, 8'h00, q);
    {RAIL_A_PWR, RAIL_B_PWR, RAIL_C_PWR} = 24'h808080;
    pulse(8, 3'h2);
    rc(8'h0C, 8'hFF);
    conclude();
  end
endmodule
`default_nettype wire
